// ===== plb_pkg.sv
// Shared constants, types and a window helper function for the locked-access PCI agents.
// Notes on behaviour
// - Completed locked data phase locks target to initiator.
// - Locked target refuses every other initiator.
// - Non-owners drive the lock line only while starting a locked access.
// - Owner continues with frame, lock deasserted.
// - Target keeps lock on owner continuation access.
// - Frame and lock both high clears lock.
// - Skip idle only after write, same target.
// - Only same-target write-first back-to-back supported.
// - Target decodes address right after own write.
// - Target drops ready lines; initiator starts next address.
// - Address phase: frame, address, command, ready lines released.
// - Write data phase: data, enables, ready, last frame.
// - Devsel claims, trdy readies, waits move nothing.
// - After last transfer: negate, release, turn around.
// - First locked access reads; abort drops lock. A first locked write is not refused here and also takes the lock.
// - Device follows lock protocol both as target and as initiator.
package plb_pkg;

  // ****************************************************************
  // Bus widths and encodings
  // ****************************************************************
  localparam int          AD_W           = 32;
  localparam int          CBE_W          = 4;
  localparam int          ID_W           = 4;
  localparam logic [3:0]  CMD_MEM_RD     = 4'h6;
  localparam logic [3:0]  CMD_MEM_WR     = 4'h7;
  localparam logic [3:0]  BE_ALL         = 4'h0;
  localparam logic [2:0]  DEVSEL_TIMEOUT = 3'h5;
  localparam int          ADDR_LSB       = 2;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic        RST_LOCKED     = 1'b0;
  localparam logic [3:0]  RST_OWNER      = 4'h0;
  localparam logic [31:0] RST_WORD       = 32'h0000_0000;

  // ****************************************************************
  // State types
  // ****************************************************************
  typedef enum logic [4:0] {
    T_IDLE  = 5'h01,
    T_TA    = 5'h02,
    T_DATA  = 5'h04,
    T_RETRY = 5'h08,
    T_DONE  = 5'h10
  } plb_tstate_t;

  typedef enum logic [3:0] {
    I_IDLE = 4'h1,
    I_ADDR = 4'h2,
    I_DATA = 4'h4,
    I_TURN = 4'h8
  } plb_istate_t;

  // Target window number of an address; both ends decode the same way.
  function automatic logic [31:0] plb_win(input logic [31:0] a, input int unsigned sh);
    plb_win = a >> sh;
  endfunction : plb_win

endpackage : plb_pkg

// ===== plb_bus_if.sv
// Shared bus between the target and the initiator, with pull-up resolution.
`timescale 1ns/100ps
interface plb_bus_if;
  import plb_pkg::*;

  logic              ini_frame_o;
  logic              ini_frame_oe;
  logic              ini_irdy_o;
  logic              ini_irdy_oe;
  logic              ini_lock_o;
  logic              ini_lock_oe;
  logic [AD_W-1:0]   ini_ad_o;
  logic              ini_ad_oe;
  logic [CBE_W-1:0]  ini_cbe_o;
  logic [ID_W-1:0]   ini_id_o;
  logic              ini_id_oe;
  logic              tgt_trdy_o;
  logic              tgt_devsel_o;
  logic              tgt_stop_o;
  logic              tgt_ctl_oe;
  logic [AD_W-1:0]   tgt_ad_o;
  logic              tgt_ad_oe;

  logic              frame_n;
  logic              irdy_n;
  logic              lock_n;
  logic              trdy_n;
  logic              devsel_n;
  logic              stop_n;
  logic [AD_W-1:0]   ad;
  logic [CBE_W-1:0]  cbe;
  logic [ID_W-1:0]   id;

  // Undriven control lines float high through the bus pull-ups.
  assign frame_n  = ini_frame_oe ? ini_frame_o : 1'b1;
  assign irdy_n   = ini_irdy_oe ? ini_irdy_o : 1'b1;
  assign lock_n   = ini_lock_oe ? ini_lock_o : 1'b1;
  assign trdy_n   = tgt_ctl_oe ? tgt_trdy_o : 1'b1;
  assign devsel_n = tgt_ctl_oe ? tgt_devsel_o : 1'b1;
  assign stop_n   = tgt_ctl_oe ? tgt_stop_o : 1'b1;
  assign ad       = ini_ad_oe ? ini_ad_o : (tgt_ad_oe ? tgt_ad_o : '0);
  assign cbe      = ini_ad_oe ? ini_cbe_o : '1;
  assign id       = ini_id_oe ? ini_id_o : '0;

  modport tgt (
    input  frame_n, irdy_n, lock_n, ad, cbe, id,
    output tgt_trdy_o, tgt_devsel_o, tgt_stop_o, tgt_ctl_oe, tgt_ad_o, tgt_ad_oe
  );

  modport ini (
    input  frame_n, irdy_n, lock_n, trdy_n, devsel_n, stop_n, ad,
    output ini_frame_o, ini_frame_oe, ini_irdy_o, ini_irdy_oe, ini_lock_o, ini_lock_oe,
           ini_ad_o, ini_ad_oe, ini_cbe_o, ini_id_o, ini_id_oe
  );

endinterface : plb_bus_if

// ===== plb_target.sv
// Lockable bus target with back-to-back decode and a small word memory.
`timescale 1ns/100ps
module plb_target
  import plb_pkg::*;
#(
  parameter logic [31:0] BASE = 32'h1000_0000,
  parameter int          AW   = 4
) (
  input  wire logic              I_CORE_CLK,
  input  wire logic              I_RSTN,
  plb_bus_if.tgt                 BUS,
  input  wire logic              I_WAIT,
  output logic                   O_WR_VALID,
  output logic [AW-1:0]          O_WR_ADDR,
  output logic [AD_W-1:0]        O_WR_DATA,
  output logic [CBE_W-1:0]       O_WR_BE,
  output logic                   O_REFUSED,
  output logic                   O_LOCKED,
  output logic [ID_W-1:0]        O_OWNER
);

  localparam int          DEPTH  = 1 << AW;
  localparam int unsigned WIN_SH = AW + ADDR_LSB;

  // ****************************************************************
  // State
  // ****************************************************************
  plb_tstate_t        st_ff,        nxt_st;
  logic               frame_q_ff,   nxt_frame_q;
  logic               lock_att_ff,  nxt_lock_att;
  logic [ID_W-1:0]    id_ff,        nxt_id;
  logic               wr_ff,        nxt_wr;
  logic [AW-1:0]      addr_ff,      nxt_addr;
  logic               locked_ff,    nxt_locked;
  logic [ID_W-1:0]    owner_ff,     nxt_owner;
  logic               trdy_ff,      nxt_trdy;
  logic               devsel_ff,    nxt_devsel;
  logic               stop_ff,      nxt_stop;
  logic               ctl_oe_ff,    nxt_ctl_oe;
  logic [AD_W-1:0]    ad_ff,        nxt_ad;
  logic               ad_oe_ff,     nxt_ad_oe;
  logic               wr_valid_ff,  nxt_wr_valid;
  logic [AW-1:0]      wr_addr_ff,   nxt_wr_addr;
  logic [AD_W-1:0]    wr_data_ff,   nxt_wr_data;
  logic [CBE_W-1:0]   wr_be_ff,     nxt_wr_be;
  logic               refused_ff,   nxt_refused;

  logic [AD_W-1:0]    mem [0:DEPTH-1];
  logic               mem_we;
  logic [AW-1:0]      addr_inc;
  logic               xfer;
  logic               addr_start;
  logic               hit;
  logic               allowed;

  // ****************************************************************
  // Decode
  // ****************************************************************
  assign addr_inc = addr_ff + {{(AW-1){1'b0}}, 1'b1};
  // A transfer happens on an edge where both ready lines are low on the bus.
  assign xfer     = ctl_oe_ff & ~trdy_ff & ~BUS.irdy_n;
  // A falling frame opens an address phase, also right after our own write.
  assign addr_start = ~BUS.frame_n & frame_q_ff &
                      ((st_ff == T_IDLE) | (st_ff == T_DONE));
  assign hit      = (plb_win(BUS.ad, WIN_SH) == plb_win(BASE, WIN_SH)) &
                    ((BUS.cbe == CMD_MEM_RD) | (BUS.cbe == CMD_MEM_WR));
  // Only the owner, arriving with the lock line released, may pass a held lock.
  assign allowed  = ~locked_ff | ((BUS.id == owner_ff) & BUS.lock_n);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    nxt_st       = st_ff;
    nxt_frame_q  = BUS.frame_n;
    nxt_lock_att = lock_att_ff;
    nxt_id       = id_ff;
    nxt_wr       = wr_ff;
    nxt_addr     = addr_ff;
    nxt_locked   = locked_ff;
    nxt_owner    = owner_ff;
    nxt_trdy     = trdy_ff;
    nxt_devsel   = devsel_ff;
    nxt_stop     = stop_ff;
    nxt_ctl_oe   = ctl_oe_ff;
    nxt_ad       = ad_ff;
    nxt_ad_oe    = ad_oe_ff;
    nxt_wr_valid = 1'b0;
    nxt_wr_addr  = wr_addr_ff;
    nxt_wr_data  = wr_data_ff;
    nxt_wr_be    = wr_be_ff;
    nxt_refused  = 1'b0;
    mem_we       = 1'b0;

    // The lock is dropped once frame and lock are seen high together.
    if (locked_ff && BUS.frame_n && BUS.lock_n) begin
      nxt_locked = 1'b0;
    end

    case (st_ff)
      T_IDLE, T_DONE: begin
        if (st_ff == T_DONE) begin
          nxt_st     = T_IDLE;
          nxt_ctl_oe = 1'b0;
          nxt_ad_oe  = 1'b0;
        end
        if (addr_start && hit) begin
          nxt_id       = BUS.id;
          nxt_addr     = BUS.ad[AW+ADDR_LSB-1:ADDR_LSB];
          nxt_wr       = (BUS.cbe == CMD_MEM_WR);
          nxt_lock_att = BUS.lock_n;
          nxt_ctl_oe   = 1'b1;
          nxt_devsel   = 1'b0;
          nxt_ad_oe    = 1'b0;
          if (!allowed) begin
            // Retry: claim, stop, never ready, so no data moves.
            nxt_st      = T_RETRY;
            nxt_stop    = 1'b0;
            nxt_trdy    = 1'b1;
            nxt_refused = 1'b1;
          end else if (BUS.cbe == CMD_MEM_WR) begin
            nxt_st   = T_DATA;
            nxt_stop = 1'b1;
            nxt_trdy = I_WAIT;
          end else begin
            // Reads leave one clock for the address lines to turn around.
            nxt_st   = T_TA;
            nxt_stop = 1'b1;
            nxt_trdy = 1'b1;
          end
        end
      end
      T_TA: begin
        nxt_st    = T_DATA;
        nxt_ad    = mem[addr_ff];
        nxt_ad_oe = 1'b1;
        nxt_trdy  = I_WAIT;
      end
      T_DATA: begin
        if (xfer) begin
          if (wr_ff) begin
            mem_we       = 1'b1;
            nxt_wr_valid = 1'b1;
            nxt_wr_addr  = addr_ff;
            nxt_wr_data  = BUS.ad;
            nxt_wr_be    = BUS.cbe;
          end
          nxt_addr = addr_inc;
          // Lock line released at address, asserted at the completed data phase.
          if (lock_att_ff && !BUS.lock_n) begin
            nxt_locked = 1'b1;
            nxt_owner  = id_ff;
          end
          if (BUS.frame_n) begin
            nxt_st     = T_DONE;
            nxt_trdy   = 1'b1;
            nxt_devsel = 1'b1;
            nxt_stop   = 1'b1;
            nxt_ad_oe  = 1'b0;
          end else begin
            nxt_trdy = I_WAIT;
            nxt_ad   = mem[addr_inc];
          end
        end else if (trdy_ff) begin
          // Once asserted, ready holds until the initiator takes the data.
          nxt_trdy = I_WAIT;
        end
      end
      T_RETRY: begin
        if (BUS.frame_n) begin
          nxt_st     = T_DONE;
          nxt_devsel = 1'b1;
          nxt_stop   = 1'b1;
        end
      end
      default: begin
        nxt_st     = T_IDLE;
        nxt_ctl_oe = 1'b0;
        nxt_ad_oe  = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      st_ff       <= T_IDLE;
      frame_q_ff  <= 1'b1;
      lock_att_ff <= 1'b0;
      id_ff       <= RST_OWNER;
      wr_ff       <= 1'b0;
      addr_ff     <= '0;
      locked_ff   <= RST_LOCKED;
      owner_ff    <= RST_OWNER;
      trdy_ff     <= 1'b1;
      devsel_ff   <= 1'b1;
      stop_ff     <= 1'b1;
      ctl_oe_ff   <= 1'b0;
      ad_ff       <= RST_WORD;
      ad_oe_ff    <= 1'b0;
      wr_valid_ff <= 1'b0;
      wr_addr_ff  <= '0;
      wr_data_ff  <= RST_WORD;
      wr_be_ff    <= '1;
      refused_ff  <= 1'b0;
    end else begin
      st_ff       <= nxt_st;
      frame_q_ff  <= nxt_frame_q;
      lock_att_ff <= nxt_lock_att;
      id_ff       <= nxt_id;
      wr_ff       <= nxt_wr;
      addr_ff     <= nxt_addr;
      locked_ff   <= nxt_locked;
      owner_ff    <= nxt_owner;
      trdy_ff     <= nxt_trdy;
      devsel_ff   <= nxt_devsel;
      stop_ff     <= nxt_stop;
      ctl_oe_ff   <= nxt_ctl_oe;
      ad_ff       <= nxt_ad;
      ad_oe_ff    <= nxt_ad_oe;
      wr_valid_ff <= nxt_wr_valid;
      wr_addr_ff  <= nxt_wr_addr;
      wr_data_ff  <= nxt_wr_data;
      wr_be_ff    <= nxt_wr_be;
      refused_ff  <= nxt_refused;
    end
  end

  // Memory has no reset; its contents are undefined until written.
  always_ff @(posedge I_CORE_CLK) begin
    if (mem_we) begin
      for (int b = 0; b < CBE_W; b++) begin
        if (!BUS.cbe[b]) begin
          mem[addr_ff][8*b +: 8] <= BUS.ad[8*b +: 8];
        end
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign BUS.tgt_trdy_o   = trdy_ff;
  assign BUS.tgt_devsel_o = devsel_ff;
  assign BUS.tgt_stop_o   = stop_ff;
  assign BUS.tgt_ctl_oe   = ctl_oe_ff;
  assign BUS.tgt_ad_o     = ad_ff;
  assign BUS.tgt_ad_oe    = ad_oe_ff;
  assign O_WR_VALID       = wr_valid_ff;
  assign O_WR_ADDR        = wr_addr_ff;
  assign O_WR_DATA        = wr_data_ff;
  assign O_WR_BE          = wr_be_ff;
  assign O_REFUSED        = refused_ff;
  assign O_LOCKED         = locked_ff;
  assign O_OWNER          = owner_ff;

endmodule : plb_target

// ===== plb_initiator.sv
// Single-beat bus initiator with lock ownership and same-target back-to-back writes.
`timescale 1ns/100ps
module plb_initiator
  import plb_pkg::*;
#(
  parameter logic [ID_W-1:0] INIT_ID = 4'h1,
  parameter int unsigned     WIN_SH  = 6
) (
  input  wire logic             I_CORE_CLK,
  input  wire logic             I_RSTN,
  plb_bus_if.ini                BUS,
  input  wire logic             I_CMD_VALID,
  input  wire logic             I_CMD_WRITE,
  input  wire logic             I_CMD_LOCK,
  input  wire logic             I_CMD_KEEP,
  input  wire logic [AD_W-1:0]  I_CMD_ADDR,
  input  wire logic [AD_W-1:0]  I_CMD_WDATA,
  output logic                  O_CMD_READY,
  output logic                  O_DONE,
  output logic [AD_W-1:0]       O_RDATA,
  output logic                  O_REFUSED,
  output logic                  O_ABORT,
  output logic                  O_LOCK_OWNED
);

  plb_istate_t       st_ff,  nxt_st;
  logic              hv_ff,  nxt_hv;
  logic              hw_ff,  nxt_hw;
  logic              hl_ff,  nxt_hl;
  logic              hk_ff,  nxt_hk;
  logic [AD_W-1:0]   ha_ff,  nxt_ha;
  logic [AD_W-1:0]   hd_ff,  nxt_hd;
  logic              cw_ff,  nxt_cw;
  logic              cl_ff,  nxt_cl;
  logic              ck_ff,  nxt_ck;
  logic [AD_W-1:0]   ca_ff,  nxt_ca;
  logic [AD_W-1:0]   cd_ff,  nxt_cd;
  logic [2:0]        cnt_ff, nxt_cnt;
  logic              own_ff, nxt_own;
  logic              fo_ff,  nxt_fo;
  logic              foe_ff, nxt_foe;
  logic              io_ff,  nxt_io;
  logic              ioe_ff, nxt_ioe;
  logic              lo_ff,  nxt_lo;
  logic              loe_ff, nxt_loe;
  logic [AD_W-1:0]   ad_ff,  nxt_ad;
  logic              aoe_ff, nxt_aoe;
  logic [CBE_W-1:0]  cbe_ff, nxt_cbe;
  logic              ido_ff, nxt_ido;
  logic              rdy_ff;
  logic              done_ff, nxt_done;
  logic [AD_W-1:0]   rd_ff,  nxt_rd;
  logic              ref_ff, nxt_ref;
  logic              ab_ff,  nxt_ab;
  logic              lock_ok;
  logic              go;
  logic              ok;
  logic              stop;
  logic              tmo;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // A new lock is only tried while the lock line is released or already owned here.
  assign lock_ok = ~hl_ff | own_ff | BUS.lock_n;
  assign ok      = ~BUS.trdy_n & ~BUS.devsel_n;
  assign stop    = ~BUS.stop_n;
  assign tmo     = BUS.devsel_n & (cnt_ff == DEVSEL_TIMEOUT - 3'h1);

  always_comb begin
    nxt_st = st_ff;  nxt_hv = hv_ff;  nxt_hw = hw_ff;  nxt_hl = hl_ff;
    nxt_hk = hk_ff;  nxt_ha = ha_ff;  nxt_hd = hd_ff;  nxt_cw = cw_ff;
    nxt_cl = cl_ff;  nxt_ck = ck_ff;  nxt_ca = ca_ff;  nxt_cd = cd_ff;
    nxt_cnt = cnt_ff; nxt_own = own_ff; nxt_fo = fo_ff; nxt_foe = foe_ff;
    nxt_io = io_ff;  nxt_ioe = ioe_ff; nxt_lo = lo_ff; nxt_loe = loe_ff;
    nxt_ad = ad_ff;  nxt_aoe = aoe_ff; nxt_cbe = cbe_ff; nxt_ido = 1'b0;
    nxt_done = 1'b0; nxt_rd = rd_ff;  nxt_ref = 1'b0; nxt_ab = 1'b0;
    go = 1'b0;
    if (I_CMD_VALID && rdy_ff) begin
      nxt_hv = 1'b1;         nxt_hw = I_CMD_WRITE; nxt_hl = I_CMD_LOCK;
      nxt_hk = I_CMD_KEEP;   nxt_ha = I_CMD_ADDR;  nxt_hd = I_CMD_WDATA;
    end
    case (st_ff)
      I_IDLE: begin
        nxt_loe = own_ff;
        nxt_lo  = ~own_ff;
        go = hv_ff & BUS.frame_n & BUS.irdy_n & lock_ok;
      end
      I_ADDR: begin
        nxt_st  = I_DATA;
        nxt_fo  = 1'b1;
        nxt_io  = 1'b0;
        nxt_ioe = 1'b1;
        nxt_ad  = cd_ff;
        nxt_aoe = cw_ff;
        nxt_cbe = BE_ALL;
        nxt_cnt = 3'h0;
        if (cl_ff) begin
          nxt_lo = 1'b0;
        end
      end
      I_DATA: begin
        nxt_cnt = cnt_ff + 3'h1;
        if (ok || stop || tmo) begin
          nxt_st   = I_TURN;
          nxt_io   = 1'b1;
          nxt_foe  = 1'b0;
          nxt_aoe  = 1'b0;
          nxt_done = ok;
          nxt_ref  = stop & ~ok;
          nxt_ab   = tmo & ~ok & ~stop;
          if (ok && !cw_ff) begin
            nxt_rd = BUS.ad;
          end
          if (cl_ff) begin
            // A failed first locked access gives the lock line back.
            nxt_own = ok ? ck_ff : own_ff;
            nxt_lo  = ~(ok ? ck_ff : own_ff);
          end
          go = ok & cw_ff & hv_ff & lock_ok &
               (plb_win(ha_ff, WIN_SH) == plb_win(ca_ff, WIN_SH));
        end
      end
      I_TURN: begin
        nxt_st  = I_IDLE;
        nxt_ioe = 1'b0;
        nxt_loe = own_ff;
      end
      default: begin
        nxt_st = I_IDLE;
      end
    endcase
    if (go) begin
      nxt_st  = I_ADDR;
      nxt_hv  = 1'b0;
      nxt_cw  = hw_ff;  nxt_cl = hl_ff; nxt_ck = hk_ff; nxt_ca = ha_ff; nxt_cd = hd_ff;
      nxt_fo  = 1'b0;   nxt_foe = 1'b1;
      nxt_io  = 1'b1;
      nxt_ad  = ha_ff;  nxt_aoe = 1'b1;
      nxt_cbe = hw_ff ? CMD_MEM_WR : CMD_MEM_RD;
      nxt_ido = 1'b1;
      if (hl_ff) begin
        nxt_loe = 1'b1;
        nxt_lo  = 1'b1;
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      st_ff <= I_IDLE; hv_ff <= 1'b0; hw_ff <= 1'b0; hl_ff <= 1'b0; hk_ff <= 1'b0;
      ha_ff <= RST_WORD; hd_ff <= RST_WORD; cw_ff <= 1'b0; cl_ff <= 1'b0;
      ck_ff <= 1'b0; ca_ff <= RST_WORD; cd_ff <= RST_WORD; cnt_ff <= 3'h0;
      own_ff <= 1'b0; fo_ff <= 1'b1; foe_ff <= 1'b0; io_ff <= 1'b1; ioe_ff <= 1'b0;
      lo_ff <= 1'b1; loe_ff <= 1'b0; ad_ff <= RST_WORD; aoe_ff <= 1'b0;
      cbe_ff <= '1; ido_ff <= 1'b0; rdy_ff <= 1'b1; done_ff <= 1'b0;
      rd_ff <= RST_WORD; ref_ff <= 1'b0; ab_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st; hv_ff <= nxt_hv; hw_ff <= nxt_hw; hl_ff <= nxt_hl; hk_ff <= nxt_hk;
      ha_ff <= nxt_ha; hd_ff <= nxt_hd; cw_ff <= nxt_cw; cl_ff <= nxt_cl;
      ck_ff <= nxt_ck; ca_ff <= nxt_ca; cd_ff <= nxt_cd; cnt_ff <= nxt_cnt;
      own_ff <= nxt_own; fo_ff <= nxt_fo; foe_ff <= nxt_foe; io_ff <= nxt_io;
      ioe_ff <= nxt_ioe; lo_ff <= nxt_lo; loe_ff <= nxt_loe; ad_ff <= nxt_ad;
      aoe_ff <= nxt_aoe; cbe_ff <= nxt_cbe; ido_ff <= nxt_ido; rdy_ff <= ~nxt_hv;
      done_ff <= nxt_done; rd_ff <= nxt_rd; ref_ff <= nxt_ref; ab_ff <= nxt_ab;
    end
  end

  assign BUS.ini_frame_o  = fo_ff;
  assign BUS.ini_frame_oe = foe_ff;
  assign BUS.ini_irdy_o   = io_ff;
  assign BUS.ini_irdy_oe  = ioe_ff;
  assign BUS.ini_lock_o   = lo_ff;
  assign BUS.ini_lock_oe  = loe_ff;
  assign BUS.ini_ad_o     = ad_ff;
  assign BUS.ini_ad_oe    = aoe_ff;
  assign BUS.ini_cbe_o    = cbe_ff;
  assign BUS.ini_id_o     = INIT_ID;
  assign BUS.ini_id_oe    = ido_ff;
  assign O_CMD_READY      = rdy_ff;
  assign O_DONE           = done_ff;
  assign O_RDATA          = rd_ff;
  assign O_REFUSED        = ref_ff;
  assign O_ABORT          = ab_ff;
  assign O_LOCK_OWNED     = own_ff;

endmodule : plb_initiator

// ===== plb_lock_chk.sv
// Bus protocol checker for the lockable target and its initiator.
`timescale 1ns/100ps
module plb_lock_chk
  import plb_pkg::*;
#(
  parameter logic [31:0] BASE = 32'h1000_0000,
  parameter int          AW   = 4
) (
  input wire logic             I_CORE_CLK,
  input wire logic             I_RSTN,
  input wire logic             frame_n,
  input wire logic             irdy_n,
  input wire logic             lock_n,
  input wire logic             trdy_n,
  input wire logic             devsel_n,
  input wire logic             stop_n,
  input wire logic [AD_W-1:0]  ad,
  input wire logic [CBE_W-1:0] cbe
);
  logic [3:0] cmd_ff;
  logic [3:0] nxt_cmd;
  logic       lk_ff;
  logic       nxt_lk;
  logic       win;
  logic       xfer;
  assign win  = (ad >> (AW + 2)) == (BASE >> (AW + 2));
  assign xfer = !irdy_n && !trdy_n;
  // ****************************************************************
  // Command of the transaction on the bus
  // ****************************************************************
  always_comb begin
    nxt_cmd = (!frame_n && irdy_n && trdy_n) ? cbe : cmd_ff;
    // A locked transfer needs the lock line released at its address in the window.
    nxt_lk  = (!frame_n && irdy_n && trdy_n) ? (lock_n || !win) : lk_ff;
  end
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      cmd_ff <= 4'h0;
      lk_ff  <= 1'b1;
    end else begin
      cmd_ff <= nxt_cmd;
      lk_ff  <= nxt_lk;
    end
  end
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RSTN);
  AST_TRDY_CLAIM: assert property (!trdy_n |-> !devsel_n)
    else $error("trdy without devsel");
  AST_REFUSE: assert property (!stop_n |-> trdy_n && !devsel_n)
    else $error("refusal moved data");
  AST_ADDR_TURN: assert property ($fell(frame_n) |-> irdy_n && trdy_n && devsel_n)
    else $error("ready lines driven in address phase");
  AST_WR_CLAIM: assert property ($fell(frame_n) && win && cbe == CMD_MEM_WR |=> !devsel_n)
    else $error("write address not claimed");
  AST_RD_TURN: assert property ($fell(frame_n) && win && cbe == CMD_MEM_RD |=> trdy_n)
    else $error("read without turnaround");
  AST_LAST: assert property (xfer && frame_n |=> trdy_n && devsel_n && irdy_n)
    else $error("ready lines not negated after last transfer");
  AST_B2B: assert property (xfer && frame_n && cmd_ff != CMD_MEM_WR |=> frame_n)
    else $error("no idle after read");
  AST_LOCK_ADDR: assert property (xfer && !lock_n |-> lk_ff)
    else $error("locked transfer without lock released at address");
  AST_WR_BE: assert property (!irdy_n && cmd_ff == CMD_MEM_WR |-> cbe == BE_ALL)
    else $error("write byte enables wrong");
endmodule : plb_lock_chk

// ===== tb_pci_lock_and_fast_b2b.sv
// Testbench joining the initiator and the target over one bus.
`timescale 1ns/100ps
`define CHK(a, b, m) begin total_checks++; if ((a) !== (b)) begin bad_count++; $display("BAD %0t %s", $time, m); end end
module tb_pci_lock_and_fast_b2b;
  import plb_pkg::*;
  logic        clk, rstn, wt, cv, cw, cl, ck, crdy, done, refd, abrt, own, wv, tref, tlk;
  logic [31:0] ca, cd, rd, wd, st;
  logic [3:0]  wa, wbe, town;
  logic [35:0] e;
  logic [35:0] exp_q[$];
  logic [35:0] wr_q[$];
  logic [31:0] mem[16];
  int          bad_count, total_checks;
  plb_bus_if plb_bus_if_i ();
  plb_target plb_target_i (.I_CORE_CLK(clk), .I_RSTN(rstn), .BUS(plb_bus_if_i), .I_WAIT(wt),
    .O_WR_VALID(wv), .O_WR_ADDR(wa), .O_WR_DATA(wd), .O_WR_BE(wbe), .O_REFUSED(tref),
    .O_LOCKED(tlk), .O_OWNER(town));
  plb_initiator plb_initiator_i (.I_CORE_CLK(clk), .I_RSTN(rstn), .BUS(plb_bus_if_i),
    .I_CMD_VALID(cv), .I_CMD_WRITE(cw), .I_CMD_LOCK(cl), .I_CMD_KEEP(ck), .I_CMD_ADDR(ca),
    .I_CMD_WDATA(cd), .O_CMD_READY(crdy), .O_DONE(done), .O_RDATA(rd), .O_REFUSED(refd),
    .O_ABORT(abrt), .O_LOCK_OWNED(own));
  plb_lock_chk plb_lock_chk_i (.I_CORE_CLK(clk), .I_RSTN(rstn), .frame_n(plb_bus_if_i.frame_n),
    .irdy_n(plb_bus_if_i.irdy_n), .lock_n(plb_bus_if_i.lock_n), .trdy_n(plb_bus_if_i.trdy_n),
    .devsel_n(plb_bus_if_i.devsel_n), .stop_n(plb_bus_if_i.stop_n), .ad(plb_bus_if_i.ad),
    .cbe(plb_bus_if_i.cbe));
  function logic [31:0] rnd();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction : rnd
  // Valid stays up at the end so that queued commands can run back to back.
  task send(input logic w, input logic l, input logic k, input logic [31:0] a,
            input logic [2:0] kind);
    cv = 1'b1; cw = w; cl = l; ck = k; ca = a; cd = rnd();
    if (kind == 3'b001 && w) begin
      mem[a[5:2]] = cd;
      wr_q.push_back({a[5:2], cd});
    end
    exp_q.push_back({kind, !w, mem[a[5:2]]});
    do @(negedge clk); while (crdy !== 1'b1);
    @(posedge clk);
    #1;
  endtask : send
  task idle(input int n);
    cv = 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  task end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    #1 wt = (rnd() & 32'h3) == 32'h0;
  end
  always @(negedge clk) begin
    if ({abrt, refd, done} !== 3'b000) begin
      e = exp_q.pop_front();
      `CHK({abrt, refd, done}, e[35:33], "result kind")
      if (e[32] && e[33]) `CHK(rd, e[31:0], "read data")
    end
    if (wv !== 1'b0) begin
      e = wr_q.pop_front();
      `CHK({wa, wd, wbe}, {e[35:0], BE_ALL}, "write word")
    end
    if (tref !== 1'b0) begin
      `CHK({tlk, town}, {1'b1, 4'h1}, "refused while unlocked")
    end
  end
  initial begin
    #(8 * 5000);
    bad_count++;
    end_sim();
  end
  initial begin
    st = 32'hF3083AA5; rstn = 1'b0; wt = 1'b0; cv = 1'b0; cw = 1'b0; cl = 1'b0; ck = 1'b0;
    ca = 32'h0; cd = 32'h0;
    repeat (10) @(posedge clk);
    #1 rstn = 1'b1;
    `CHK({tlk, town}, {RST_LOCKED, RST_OWNER}, "unlocked after reset")
    for (int i = 0; i < 16; i++) send(1'b1, 1'b0, 1'b0, 32'h1000_0000 | (i << 2), 3'b001);
    idle(8);
    $display("test back to back writes done");
    for (int i = 0; i < 6; i++) send(1'b0, 1'b0, 1'b0, 32'h1000_0000 | (i << 2), 3'b001);
    send(1'b1, 1'b0, 1'b0, 32'h2000_0000, 3'b100);
    idle(12);
    $display("test reads and abort done");
    send(1'b0, 1'b1, 1'b1, 32'h1000_0000, 3'b001);
    idle(8);
    `CHK({tlk, town, own}, {1'b1, 4'h1, 1'b1}, "lock owner")
    send(1'b1, 1'b1, 1'b1, 32'h1000_0004, 3'b001);
    idle(8);
    `CHK(tlk, 1'b1, "lock kept")
    send(1'b0, 1'b0, 1'b0, 32'h1000_000C, 3'b010);
    send(1'b0, 1'b1, 1'b0, 32'h1000_0008, 3'b001);
    idle(8);
    `CHK({tlk, own}, 2'b00, "lock cleared")
    $display("test lock sequence done");
    `CHK(exp_q.size() + wr_q.size(), 0, "results outstanding")
    end_sim();
  end
endmodule : tb_pci_lock_and_fast_b2b
